//--- hw/sdp_top.sv
// Purpose: Byte-wide DIO ports run by a stored script, with indexed read results
// Assumes: AXI4-Lite master keeps one write and one read outstanding at most
// Notes: Script runs one command per clock; pins are synchronised by two flops
// Notes on behaviour
// - Configure-line sets direction of one selected line; other lines keep theirs.
// - Configure-port bitmap: bit one makes line output, zero makes input.
// - Configure-port updates all eight lines of the port together.
// - Every command names a port; single-port devices use port zero.
// - Read-line samples the selected line of the selected port.
// - Read-line result is zero for low, one for high.
// - Read-port samples all eight bits together as one byte.
// - Read results stored under command index; host fetches after the script.
// - Write-line value one drives line high, zero drives it low.
// - Whole-port write changes only lines configured as outputs.
`include "sdp_params.svh"
module sdp_top #(
  parameter int PORTS = 1,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [PORTS*8-1:0] dio_in,
  output logic [PORTS*8-1:0] dio_out,
  output logic [PORTS*8-1:0] dio_oe
);
  localparam int IW = $clog2(DEPTH);
  localparam int NL = PORTS * 8;
  // Refuse sizes the index logic cannot serve
  if (PORTS < 1 || PORTS > 256 || DEPTH < 2 || DEPTH > 256 || (1 << IW) != DEPTH) begin : g_chk
    $error("sdp_top: PORTS or DEPTH out of range");
  end
  logic [31:0] smem [DEPTH];
  logic [7:0] res_q [DEPTH];
  logic [NL-1:0] sync1_q, din_q;
  logic [7:0] aw_addr_q, aw_addr_d, len_q, len_d, waddr, raddr, pc_q, pc_d, res_val, pbyte;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d, wm;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [IW-1:0] saddr_q, saddr_d, ridx_q, ridx_d;
  logic do_wr, go, sm_we, done_q, done_d, port_ok, last, res_we;
  sdp_pkg::sdp_state_type st_q, st_d;
  logic [NL-1:0] dir_q, dir_d, out_q, out_d, lmask, pmask;
  sdp_pkg::sdp_cmd_type cmd;
  int pidx;
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign dio_out = out_q;
  assign dio_oe = dir_q;
  // Two-flop synchroniser on the pins
  always_ff @(posedge aclk) begin
    sync1_q <= dio_in;
    din_q <= sync1_q;
  end
  // Bus next state: address and data taken in either order
  always_comb begin
    wm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    bvalid_d = bvalid_q && !bready; // Response leaves at its handshake
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    len_d = len_q;
    saddr_d = saddr_q;
    ridx_d = ridx_q;
    go = 1'b0;
    sm_we = 1'b0;
    waddr = {aw_addr_q[7:2], 2'b00};
    raddr = {araddr[7:2], 2'b00};
    if (awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = wdata & wm;
    end
    do_wr = aw_full_q && w_full_q && !bvalid_q;
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `SDP_RESP_OK;
      unique case (waddr)
        `SDP_OFF_CTRL: begin
          if (w_data_q[`SDP_RUN_BIT] && st_q == sdp_pkg::st_idle) begin
            go = 1'b1;
            len_d = w_data_q[`SDP_LEN_LSB +: 8];
          end
        end
        `SDP_OFF_SADDR: saddr_d = w_data_q[IW-1:0];
        `SDP_OFF_SDATA: begin
          // Script edits are ignored while it runs
          if (st_q == sdp_pkg::st_idle) begin
            sm_we = 1'b1;
            saddr_d = saddr_q + 1'b1;
          end
        end
        `SDP_OFF_RIDX: ridx_d = w_data_q[IW-1:0];
        `SDP_OFF_STAT, `SDP_OFF_RDATA, `SDP_OFF_DIR, `SDP_OFF_OUT: ;
        default: bresp_d = `SDP_RESP_ERR;
      endcase
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `SDP_RESP_OK;
      rdata_d = '0;
      unique case (raddr)
        `SDP_OFF_CTRL: rdata_d[`SDP_LEN_LSB +: 8] = len_q;
        `SDP_OFF_STAT: begin
          rdata_d[`SDP_BUSY_BIT] = (st_q == sdp_pkg::st_exec);
          rdata_d[`SDP_DONE_BIT] = done_q;
        end
        `SDP_OFF_SADDR: rdata_d[IW-1:0] = saddr_q;
        `SDP_OFF_SDATA: rdata_d = smem[saddr_q];
        `SDP_OFF_RIDX: rdata_d[IW-1:0] = ridx_q;
        `SDP_OFF_RDATA: rdata_d[7:0] = res_q[ridx_q];
        `SDP_OFF_DIR: rdata_d[7:0] = dir_q[7:0];
        `SDP_OFF_OUT: rdata_d[7:0] = din_q[7:0];
        default: rresp_d = `SDP_RESP_ERR;
      endcase
    end
  end
  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= '0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `SDP_RESP_OK;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `SDP_RESP_OK;
      len_q <= '0;
      saddr_q <= '0;
      ridx_q <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      len_q <= len_d;
      saddr_q <= saddr_d;
      ridx_q <= ridx_d;
    end
  end
  // Script and result memories
  always_ff @(posedge aclk) begin
    if (sm_we) begin
      smem[saddr_q] <= w_data_q;
    end
    if (res_we) begin
      res_q[pc_q[IW-1:0]] <= res_val;
    end
  end
  // Engine next state: one command per cycle, in script order
  always_comb begin
    cmd = sdp_pkg::sdp_cmd_type'(smem[pc_q[IW-1:0]]);
    pidx = int'(cmd.port);
    port_ok = pidx < PORTS;
    lmask = '0;
    pmask = '0;
    pbyte = '0;
    if (port_ok) begin
      lmask[pidx * 8 + int'(cmd.line)] = 1'b1;
      pmask[pidx * 8 +: 8] = 8'hFF;
      pbyte = din_q[pidx * 8 +: 8];
    end
    st_d = st_q;
    pc_d = pc_q;
    done_d = done_q;
    dir_d = dir_q;
    out_d = out_q;
    res_we = 1'b0;
    res_val = '0;
    last = (pc_q + 8'h01) == len_q;
    unique case (st_q)
      sdp_pkg::st_idle: begin
        if (go) begin
          pc_d = '0;
          done_d = (len_d == '0);
          st_d = (len_d == '0) ? sdp_pkg::st_idle : sdp_pkg::st_exec;
        end
      end
      sdp_pkg::st_exec: begin
        if (port_ok) begin
          unique case (cmd.op)
            sdp_pkg::op_cfg_line: dir_d = (dir_q & ~lmask) | (cmd.value[0] ? lmask : '0);
            sdp_pkg::op_cfg_port: dir_d = (dir_q & ~pmask) | ({PORTS{cmd.value}} & pmask);
            sdp_pkg::op_rd_line: begin
              res_we = 1'b1;
              res_val = {7'h00, |(din_q & lmask)};
            end
            sdp_pkg::op_rd_port: begin
              res_we = 1'b1;
              res_val = pbyte;
            end
            sdp_pkg::op_wr_line: out_d = (out_q & ~lmask) | (cmd.value[0] ? lmask : '0);
            sdp_pkg::op_wr_port: begin
              out_d = (out_q & ~(pmask & dir_q)) | ({PORTS{cmd.value}} & pmask & dir_q);
            end
            default: ;
          endcase
        end
        pc_d = pc_q + 8'h01;
        if (last) begin
          st_d = sdp_pkg::st_idle;
          done_d = 1'b1;
        end
      end
    endcase
  end
  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= sdp_pkg::st_idle;
      pc_q <= '0;
      done_q <= 1'b0;
      dir_q <= {PORTS{`SDP_DIR_RST}};
      out_q <= {PORTS{`SDP_OUT_RST}};
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      done_q <= done_d;
      dir_q <= dir_d;
      out_q <= out_d;
    end
  end
  // Checks on the engine and the bus
  wire logic ex = (st_q == sdp_pkg::st_exec) && port_ok;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    go && st_q == sdp_pkg::st_idle && len_d != '0;
  endsequence
  sequence s_first;
    st_q == sdp_pkg::st_exec && pc_q == '0;
  endsequence
  property p_reset_in;
    $past(!aresetn) |-> dio_oe == '0;
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("lines not inputs after reset");
  property p_cfg_line;
    ex && cmd.op == sdp_pkg::op_cfg_line |=> (|(dio_oe & $past(lmask)) == $past(cmd.value[0]))
      && ((dio_oe & ~$past(lmask)) == ($past(dio_oe) & ~$past(lmask)));
  endproperty
  a_cfg_line: assert property (p_cfg_line) else $error("configure line wrong");
  property p_cfg_port;
    ex && cmd.op == sdp_pkg::op_cfg_port
      |=> (dio_oe & $past(pmask)) == ($past({PORTS{cmd.value}}) & $past(pmask));
  endproperty
  a_cfg_port: assert property (p_cfg_port) else $error("configure port wrong");
  property p_bad_port;
    st_q == sdp_pkg::st_exec && !port_ok |=> dio_oe == $past(dio_oe) && dio_out == $past(dio_out);
  endproperty
  a_bad_port: assert property (p_bad_port) else $error("absent port touched");
  property p_rd_line;
    ex && cmd.op == sdp_pkg::op_rd_line
      |=> res_q[$past(pc_q[IW-1:0])] == {7'h00, $past(|(din_q & lmask))};
  endproperty
  a_rd_line: assert property (p_rd_line) else $error("read line result wrong");
  property p_rd_port;
    ex && cmd.op == sdp_pkg::op_rd_port |=> res_q[$past(pc_q[IW-1:0])] == $past(pbyte);
  endproperty
  a_rd_port: assert property (p_rd_port) else $error("read port result wrong");
  property p_wr_line;
    ex && cmd.op == sdp_pkg::op_wr_line |=> |(dio_out & $past(lmask)) == $past(cmd.value[0]);
  endproperty
  a_wr_line: assert property (p_wr_line) else $error("write line level wrong");
  property p_wr_port;
    ex && cmd.op == sdp_pkg::op_wr_port |=> ((dio_out ^ $past(dio_out)) & ~$past(dio_oe)) == '0;
  endproperty
  a_wr_port: assert property (p_wr_port) else $error("input line changed by write");
  property p_order;
    s_start |=> s_first ##1 (pc_q == 8'h01 || st_q == sdp_pkg::st_idle);
  endproperty
  a_order: assert property (p_order) else $error("script did not start in order");
  property p_step;
    st_q == sdp_pkg::st_exec && !last |=> st_q == sdp_pkg::st_exec && pc_q == $past(pc_q) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("command skipped or repeated");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule : sdp_top

//--- hw/sdp_params.svh
// Purpose: Register offsets, field positions and reset values of the script DIO port
// Assumes: Byte addresses on a 32-bit AXI4-Lite slave, one aligned word per register
// Notes: Included by the design file and the testbench
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH
`define SDP_OFF_CTRL 8'h00
`define SDP_OFF_STAT 8'h04
`define SDP_OFF_SADDR 8'h08
`define SDP_OFF_SDATA 8'h0C
`define SDP_OFF_RIDX 8'h10
`define SDP_OFF_RDATA 8'h14
`define SDP_OFF_DIR 8'h18
`define SDP_OFF_OUT 8'h1C
`define SDP_RUN_BIT 0
`define SDP_LEN_LSB 8
`define SDP_BUSY_BIT 0
`define SDP_DONE_BIT 1
`define SDP_RESP_OK 2'b00
`define SDP_RESP_ERR 2'b10
`define SDP_DIR_RST 8'h00
`define SDP_OUT_RST 8'h00
`endif

//--- hw/sdp_pkg.sv
// Purpose: Types of the script DIO port
// Assumes: Script command words are 32 bits
// Notes: Command layout op[31:28] port[23:16] line[10:8] value[7:0]
package sdp_pkg;
  typedef enum logic [3:0] {
    op_nop = 4'h0,
    op_cfg_line = 4'h1,
    op_cfg_port = 4'h2,
    op_rd_line = 4'h3,
    op_rd_port = 4'h4,
    op_wr_line = 4'h5,
    op_wr_port = 4'h6
  } sdp_op_type;
  typedef struct packed {
    sdp_op_type op;
    logic [3:0] rsvd_a;
    logic [7:0] port;
    logic [4:0] rsvd_b;
    logic [2:0] line;
    logic [7:0] value;
  } sdp_cmd_type;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_exec = 2'b10
  } sdp_state_type;
endpackage : sdp_pkg

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the script DIO port over AXI4-Lite
// Assumes: One port of eight lines, sixteen script entries, 25 MHz clock
// Notes: Script results are fetched by index once the done flag is seen
`include "sdp_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [7:0] dio_in = 8'h00;
  logic [7:0] dio_out;
  logic [7:0] dio_oe;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [1:0] rsp;
  logic [31:0] rd;

  sdp_top #(.PORTS(1), .DEPTH(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe)
  );

  // Clock of 40 ns period
  always #20 aclk = ~aclk;

  // Ends the run in one place
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc >= 6000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end

  // Compares seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One AXI4-Lite write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok && bvalid));
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  // One AXI4-Lite read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!(ar_ok && rvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  function automatic logic [31:0] cmd(input sdp_pkg::sdp_op_type op, input logic [7:0] port,
                                      input logic [2:0] line, input logic [7:0] val);
    return {op, 4'h0, port, 5'h00, line, val};
  endfunction : cmd

  // Starts the stored script and polls until done
  task automatic run_script(input logic [7:0] len);
    axw(`SDP_OFF_CTRL, {16'h0000, len, 8'h01}, rsp);
    do begin
      axr(`SDP_OFF_STAT, rd, rsp);
    end while (rd[`SDP_DONE_BIT] !== 1'b1);
    chk({31'h0, rd[`SDP_BUSY_BIT]}, 32'h0, "busy after done");
  endtask : run_script

  // Reads the result kept under one script index
  task automatic chk_result(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    axw(`SDP_OFF_RIDX, {24'h0, idx}, rsp);
    axr(`SDP_OFF_RDATA, rd, rsp);
    chk({24'h0, rd[7:0]}, {24'h0, exp}, msg);
  endtask : chk_result

  // All lines are inputs out of reset
  task automatic test_reset;
    chk({24'h0, dio_oe}, 32'h0, "oe after reset");
    chk({24'h0, dio_out}, 32'h0, "out after reset");
    axr(`SDP_OFF_DIR, rd, rsp);
    chk({24'h0, rd[7:0]}, 32'h0, "dir reg after reset");
    $display("test_reset done");
  endtask : test_reset

  // Loads a script covering every command kind, runs it and checks each effect
  task automatic test_script;
    logic [31:0] s [0:9];
    s[0] = cmd(sdp_pkg::op_cfg_port, 8'h00, 3'h0, 8'hA5);
    s[1] = cmd(sdp_pkg::op_cfg_line, 8'h00, 3'h1, 8'h01);
    s[2] = cmd(sdp_pkg::op_cfg_line, 8'h00, 3'h7, 8'h00);
    s[3] = cmd(sdp_pkg::op_wr_port, 8'h00, 3'h0, 8'hFF);
    s[4] = cmd(sdp_pkg::op_wr_line, 8'h00, 3'h0, 8'h00);
    s[5] = cmd(sdp_pkg::op_rd_line, 8'h00, 3'h3, 8'h00);
    s[6] = cmd(sdp_pkg::op_rd_port, 8'h00, 3'h0, 8'h00);
    s[7] = cmd(sdp_pkg::op_rd_line, 8'h00, 3'h4, 8'h00);
    s[8] = cmd(sdp_pkg::op_cfg_port, 8'h01, 3'h0, 8'hFF);
    s[9] = cmd(sdp_pkg::op_nop, 8'h00, 3'h0, 8'h00);
    axw(`SDP_OFF_SADDR, 32'h0, rsp);
    for (int i = 0; i < 10; i++) begin
      axw(`SDP_OFF_SDATA, s[i], rsp);
    end
    dio_in <= 8'h4A;
    run_script(8'd10);
    chk({24'h0, dio_oe}, 32'h27, "oe after cfg");
    axr(`SDP_OFF_DIR, rd, rsp);
    chk({24'h0, rd[7:0]}, 32'h27, "dir reg");
    chk({24'h0, dio_out}, 32'h26, "out after writes");
    chk_result(8'd5, 8'h01, "line 3 high");
    chk_result(8'd6, 8'h4A, "port byte");
    chk_result(8'd7, 8'h00, "line 4 low");
    // Opposite pin levels on a second run of the same script
    dio_in <= 8'h10;
    run_script(8'd10);
    chk({24'h0, dio_oe}, 32'h27, "oe rerun, other port ignored");
    chk_result(8'd5, 8'h00, "line 3 low");
    chk_result(8'd6, 8'h10, "port byte rerun");
    chk_result(8'd7, 8'h01, "line 4 high");
    $display("test_script done");
  endtask : test_script

  // One line changed, then port bitmap applied whole over it, order kept
  task automatic test_order;
    axw(`SDP_OFF_SADDR, 32'h0, rsp);
    axw(`SDP_OFF_SDATA, cmd(sdp_pkg::op_cfg_line, 8'h00, 3'h2, 8'h00), rsp);
    axw(`SDP_OFF_SDATA, cmd(sdp_pkg::op_cfg_port, 8'h00, 3'h0, 8'h5A), rsp);
    axw(`SDP_OFF_SDATA, cmd(sdp_pkg::op_wr_line, 8'h00, 3'h6, 8'h01), rsp);
    run_script(8'd3);
    chk({24'h0, dio_oe}, 32'h5A, "bitmap replaces all lines");
    chk({24'h0, dio_out & dio_oe}, 32'h42, "line 6 driven high");
    axr(`SDP_OFF_CTRL, rd, rsp);
    chk(rd, 32'h00000300, "length read back");
    // Empty script finishes at once and touches no line
    run_script(8'h00);
    chk({24'h0, dio_oe}, 32'h5A, "empty script");
    // Disabled byte lanes are stored as zero; pointer steps after each word
    axw(`SDP_OFF_SADDR, 32'h0000000C, rsp);
    wstrb <= 4'h3;
    axw(`SDP_OFF_SDATA, 32'hFFFFFFFF, rsp);
    wstrb <= 4'hF;
    axr(`SDP_OFF_SADDR, rd, rsp);
    chk(rd, 32'h0000000D, "pointer advanced");
    axw(`SDP_OFF_SADDR, 32'h0000000C, rsp);
    axr(`SDP_OFF_SDATA, rd, rsp);
    chk(rd, 32'h0000FFFF, "byte strobes");
    axw(8'h20, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, `SDP_RESP_ERR}, "unmapped write");
    axr(8'h24, rd, rsp);
    chk({30'h0, rsp}, {30'h0, `SDP_RESP_ERR}, "unmapped read");
    chk({24'h0, dio_oe}, 32'h5A, "oe kept");
    $display("test_order done");
  endtask : test_order

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_script();
    test_order();
    print_verdict();
  end
endmodule : testbench
